/* rtl/flow_pkg.sv */
// Function
// - PC-relative direct branch adds signed 24-bit offset to current program counter.
// - Absolute direct branch takes its target from the 24-bit address field.
// - PC-relative indirect-form branch sign-extends a 6-bit offset and adds it.
// - Indirect target is index plus modify; the index register keeps its value.
// - Jump with loop abort pops the loop stacks and the program counter stack.
// - A recurring interrupt is ignored and not latched while its routine runs.
// - Jump with clear interrupt clears that interrupt's latch and mask pointer bits.
// - Branch-type bit picks jump or call; calls ignore loop abort and clear interrupt.
// - A dedicated bit picks delayed or non-delayed branch.
// - With no test condition the branch is unconditional.
// - In single-lane mode indirect-form branch runs when condition true or absent.
// - Compute without else runs alongside the jump or call.
// - Compute with else runs only when the condition is false.
// - Dual-lane conditional branch is taken only when both elements test true.
// - Dual-lane compute without else runs only in elements testing true.
// - Dual-lane else compute runs in each element whose own condition is false.
// - Dual-lane second element computes on the complementary registers.
package flow_pkg;
    // -------------------------------------------------------------------------
    // Instruction word layout
    // -------------------------------------------------------------------------
    localparam int INSTR_W = 48;
    localparam int ADDR_W = 24;
    localparam int FORM_HI = 47;
    localparam int FORM_LO = 45;
    localparam int BIT_CALL = 44;
    localparam int BIT_DELAYED = 43;
    localparam int BIT_ABORT = 42;
    localparam int BIT_CLRINT = 41;
    localparam int BIT_ELSE = 40;
    localparam int BIT_CONDP = 39;
    localparam int IDX_HI = 33;
    localparam int IDX_LO = 31;
    localparam int MOD_HI = 30;
    localparam int MOD_LO = 28;
    localparam int REL6_HI = 28;
    localparam int REL6_LO = 23;
    localparam int REL6_W = 6;
    localparam int COMP_W = 23;
    localparam logic [2:0] FORM_ABS24 = 3'h1;
    localparam logic [2:0] FORM_REL24 = 3'h2;
    localparam logic [2:0] FORM_IND = 3'h3;
    localparam logic [2:0] FORM_REL6 = 3'h4;
    // -------------------------------------------------------------------------
    // Register map, byte addresses
    // -------------------------------------------------------------------------
    localparam int BUS_AW = 7;
    localparam logic [6:0] OFS_CTRL = 7'h00;
    localparam logic [6:0] OFS_STATUS = 7'h04;
    localparam logic [6:0] OFS_LATCH = 7'h08;
    localparam logic [6:0] OFS_MASKP = 7'h0C;
    localparam logic [1:0] BANK_INDEX = 2'h1;
    localparam logic [1:0] BANK_MODIFY = 2'h2;
    localparam int CTRL_DUAL_BIT = 0;
    localparam int STATUS_TAKEN_BIT = 31;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int NUM_IRQ = 8;
    localparam int NUM_DAG = 8;
endpackage

/* rtl/lane_condition.sv */
// -----------------------------------------------------------------------------
// Per-element condition and compute gate
// -----------------------------------------------------------------------------
module lane_condition (
    input wire logic condition_field_present_in,
    input wire logic condition_field_true_in,
    input wire logic else_in,
    input wire logic lane_active_in,
    output logic condition_field_met_out,
    output logic compute_en_out
);
    // A missing condition counts as true; an else compute needs a false test.
    always_comb
    begin
        condition_field_met_out = !condition_field_present_in || condition_field_true_in;
        if (else_in)
        begin
            compute_en_out = lane_active_in && condition_field_present_in && !condition_field_true_in;
        end
        else
        begin
            compute_en_out = lane_active_in && condition_field_met_out;
        end
    end
endmodule // lane_condition

/* rtl/branch_jump_call_control.sv */
module branch_jump_call_control #(
    parameter int NUM_IRQ = flow_pkg::NUM_IRQ
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [flow_pkg::BUS_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic instr_valid_in,
    input wire logic [flow_pkg::INSTR_W-1:0] instr_word_in,
    input wire logic [flow_pkg::ADDR_W-1:0] pc_in,
    input wire logic condition_field_x_in,
    input wire logic condition_field_y_in,
    input wire logic [NUM_IRQ-1:0] irq_raise_in,
    input wire logic [NUM_IRQ-1:0] isr_enter_in,
    input wire logic isr_exit_in,
    output logic branch_taken_out,
    output logic [flow_pkg::ADDR_W-1:0] branch_target_out,
    output logic branch_call_out,
    output logic branch_delayed_out,
    output logic flush_fetched_out,
    output logic pop_loop_stacks_out,
    output logic pop_pc_stack_out,
    output logic compute_en_x_out,
    output logic compute_en_y_out,
    output logic compute_complement_y_out,
    output logic [flow_pkg::COMP_W-1:0] compute_op_out,
    output logic [NUM_IRQ-1:0] interrupt_latch_out
);
    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic dual_lane_mode_q;
    logic [flow_pkg::ADDR_W-1:0] index_q [0:flow_pkg::NUM_DAG-1];
    logic [flow_pkg::ADDR_W-1:0] modify_q [0:flow_pkg::NUM_DAG-1];
    logic [NUM_IRQ-1:0] interrupt_latch_reg;
    logic [NUM_IRQ-1:0] interrupt_mask_pointer;
    logic [NUM_IRQ-1:0] current_irq;
    logic ack_q;
    logic [31:0] rdata_d;
    logic wr_fire;
    logic [2:0] form;
    logic is_call;
    logic condition_field_present;
    logic else_bit;
    logic form_ok;
    logic is_type9;
    logic met_x;
    logic met_y;
    logic cen_x;
    logic cen_y;
    logic take;
    logic loop_abort_modifier;
    logic clear_interrupt_modifier;
    logic [2:0] idx_sel;
    logic [2:0] mod_sel;
    logic [flow_pkg::ADDR_W-1:0] target_d;
    logic [flow_pkg::ADDR_W-1:0] rel24_sum;
    logic [flow_pkg::ADDR_W-1:0] rel6_sum;
    logic [flow_pkg::ADDR_W-1:0] ind_sum;
    logic [NUM_IRQ-1:0] ci_clear;
    logic [NUM_IRQ-1:0] exit_clear;

    // -------------------------------------------------------------------------
    // Instruction decode
    // -------------------------------------------------------------------------
    // Fields and modifier qualification; calls drop abort and clear interrupt.
    always_comb
    begin
        form = instr_word_in[flow_pkg::FORM_HI:flow_pkg::FORM_LO];
        is_call = instr_word_in[flow_pkg::BIT_CALL];
        condition_field_present = instr_word_in[flow_pkg::BIT_CONDP];
        is_type9 = (form == flow_pkg::FORM_IND) || (form == flow_pkg::FORM_REL6);
        else_bit = instr_word_in[flow_pkg::BIT_ELSE] && is_type9;
        form_ok = (form == flow_pkg::FORM_ABS24) || (form == flow_pkg::FORM_REL24) || is_type9;
        loop_abort_modifier = !is_call && instr_word_in[flow_pkg::BIT_ABORT];
        clear_interrupt_modifier = !is_call && instr_word_in[flow_pkg::BIT_CLRINT];
        idx_sel = instr_word_in[flow_pkg::IDX_HI:flow_pkg::IDX_LO];
        mod_sel = instr_word_in[flow_pkg::MOD_HI:flow_pkg::MOD_LO];
    end

    // Target adders for the three computed forms.
    always_comb
    begin
        rel24_sum = pc_in + instr_word_in[flow_pkg::ADDR_W-1:0];
        rel6_sum = pc_in + {{(flow_pkg::ADDR_W-flow_pkg::REL6_W){instr_word_in[flow_pkg::REL6_HI]}},
            instr_word_in[flow_pkg::REL6_HI:flow_pkg::REL6_LO]};
        ind_sum = index_q[idx_sel] + modify_q[mod_sel];
        if (form == flow_pkg::FORM_ABS24)
        begin
            target_d = instr_word_in[flow_pkg::ADDR_W-1:0];
        end
        else if (form == flow_pkg::FORM_REL24)
        begin
            target_d = rel24_sum;
        end
        else if (form == flow_pkg::FORM_IND)
        begin
            target_d = ind_sum;
        end
        else
        begin
            target_d = rel6_sum;
        end
    end

    // Condition evaluation in each processing element.
    lane_condition u_lane_x (
        .condition_field_present_in(condition_field_present),
        .condition_field_true_in(condition_field_x_in),
        .else_in(else_bit),
        .lane_active_in(is_type9),
        .condition_field_met_out(met_x),
        .compute_en_out(cen_x)
    );

    lane_condition u_lane_y (
        .condition_field_present_in(condition_field_present),
        .condition_field_true_in(condition_field_y_in),
        .else_in(else_bit),
        .lane_active_in(is_type9 && dual_lane_mode_q),
        .condition_field_met_out(met_y),
        .compute_en_out(cen_y)
    );

    // Single lane follows the first element; dual lane needs both to be met.
    always_comb
    begin
        if (dual_lane_mode_q)
        begin
            take = instr_valid_in && form_ok && met_x && met_y;
        end
        else
        begin
            take = instr_valid_in && form_ok && met_x;
        end
    end

    // -------------------------------------------------------------------------
    // Sequencer outputs
    // -------------------------------------------------------------------------
    // Registered one-cycle branch strobes; the target holds until the next taken branch.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            branch_taken_out <= 1'b0;
            branch_target_out <= '0;
            branch_call_out <= 1'b0;
            branch_delayed_out <= 1'b0;
            flush_fetched_out <= 1'b0;
            pop_loop_stacks_out <= 1'b0;
            pop_pc_stack_out <= 1'b0;
        end
        else
        begin
            branch_taken_out <= take;
            branch_target_out <= take ? target_d : branch_target_out;
            branch_call_out <= take && is_call;
            branch_delayed_out <= take && instr_word_in[flow_pkg::BIT_DELAYED];
            flush_fetched_out <= take && !instr_word_in[flow_pkg::BIT_DELAYED];
            pop_loop_stacks_out <= take && loop_abort_modifier;
            pop_pc_stack_out <= take && loop_abort_modifier;
        end
    end

    // Registered compute enables for each element.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            compute_en_x_out <= 1'b0;
            compute_en_y_out <= 1'b0;
            compute_complement_y_out <= 1'b0;
            compute_op_out <= '0;
        end
        else
        begin
            compute_en_x_out <= instr_valid_in && cen_x;
            compute_en_y_out <= instr_valid_in && cen_y;
            compute_complement_y_out <= instr_valid_in && cen_y;
            compute_op_out <= instr_word_in[flow_pkg::COMP_W-1:0];
        end
    end

    // -------------------------------------------------------------------------
    // Interrupt latch and mask pointer
    // -------------------------------------------------------------------------
    // The current interrupt is the lowest numbered routine in service.
    always_comb
    begin
        current_irq = interrupt_mask_pointer & (~interrupt_mask_pointer + {{(NUM_IRQ-1){1'b0}}, 1'b1});
        ci_clear = (instr_valid_in && take && clear_interrupt_modifier) ? current_irq : '0;
        exit_clear = isr_exit_in ? current_irq : '0;
    end

    // A raise for a routine already in service is dropped, also in the cycle of its clear; a new raise beats an entry.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            interrupt_latch_reg <= '0;
        end
        else
        begin
            interrupt_latch_reg <= (interrupt_latch_reg & ~(isr_enter_in | ci_clear))
                | (irq_raise_in & ~interrupt_mask_pointer);
        end
    end

    // Entry sets the mask pointer bit; exit or clear interrupt removes it.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            interrupt_mask_pointer <= '0;
        end
        else
        begin
            interrupt_mask_pointer <= (interrupt_mask_pointer & ~(ci_clear | exit_clear)) | isr_enter_in;
        end
    end

    // Latch copy for the interrupt controller.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            interrupt_latch_out <= '0;
        end
        else
        begin
            interrupt_latch_out <= (interrupt_latch_reg & ~(isr_enter_in | ci_clear))
                | (irq_raise_in & ~interrupt_mask_pointer);
        end
    end

    // -------------------------------------------------------------------------
    // Avalon-MM slave
    // -------------------------------------------------------------------------
    // Read data selection; unmapped addresses read zero.
    always_comb
    begin
        rdata_d = '0;
        if (avs_address_in == flow_pkg::OFS_CTRL)
        begin
            rdata_d[flow_pkg::CTRL_DUAL_BIT] = dual_lane_mode_q;
        end
        else if (avs_address_in == flow_pkg::OFS_STATUS)
        begin
            rdata_d[flow_pkg::ADDR_W-1:0] = branch_target_out;
            rdata_d[flow_pkg::STATUS_TAKEN_BIT] = branch_taken_out;
        end
        else if (avs_address_in == flow_pkg::OFS_LATCH)
        begin
            rdata_d[NUM_IRQ-1:0] = interrupt_latch_reg;
        end
        else if (avs_address_in == flow_pkg::OFS_MASKP)
        begin
            rdata_d[NUM_IRQ-1:0] = interrupt_mask_pointer;
        end
        else if (avs_address_in[6:5] == flow_pkg::BANK_INDEX)
        begin
            rdata_d[flow_pkg::ADDR_W-1:0] = index_q[avs_address_in[4:2]];
        end
        else if (avs_address_in[6:5] == flow_pkg::BANK_MODIFY)
        begin
            rdata_d[flow_pkg::ADDR_W-1:0] = modify_q[avs_address_in[4:2]];
        end
    end

    assign wr_fire = avs_write_in && ack_q;

    // Each request waits one cycle, then waitrequest drops for exactly one cycle.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            ack_q <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= '0;
        end
        else
        begin
            ack_q <= (avs_read_in || avs_write_in) && !ack_q;
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
            avs_readdata_out <= avs_read_in ? rdata_d : '0;
        end
    end

    // Control register write with byte enables.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            dual_lane_mode_q <= flow_pkg::CTRL_RESET[flow_pkg::CTRL_DUAL_BIT];
        end
        else if (wr_fire && avs_address_in == flow_pkg::OFS_CTRL && avs_byteenable_in[0])
        begin
            dual_lane_mode_q <= avs_writedata_in[flow_pkg::CTRL_DUAL_BIT];
        end
    end

    // Index and modify banks; branches only read them.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            for (int i = 0; i < flow_pkg::NUM_DAG; i++)
            begin
                index_q[i] <= '0;
                modify_q[i] <= '0;
            end
        end
        else if (wr_fire)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (avs_byteenable_in[b] && avs_address_in[6:5] == flow_pkg::BANK_INDEX)
                begin
                    index_q[avs_address_in[4:2]][b*8 +: 8] <= avs_writedata_in[b*8 +: 8];
                end
                if (avs_byteenable_in[b] && avs_address_in[6:5] == flow_pkg::BANK_MODIFY)
                begin
                    modify_q[avs_address_in[4:2]][b*8 +: 8] <= avs_writedata_in[b*8 +: 8];
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    property p_rel24;
        @(posedge clk_in) disable iff (srst_in)
        take && form == flow_pkg::FORM_REL24 |=> branch_taken_out && branch_target_out == $past(rel24_sum);
    endproperty
    a_rel24: assert property (p_rel24) else $error("relative 24 target wrong");

    property p_abs24;
        @(posedge clk_in) disable iff (srst_in)
        take && form == flow_pkg::FORM_ABS24 |=> branch_target_out == $past(instr_word_in[23:0]);
    endproperty
    a_abs24: assert property (p_abs24) else $error("absolute target wrong");

    property p_rel6;
        @(posedge clk_in) disable iff (srst_in)
        take && form == flow_pkg::FORM_REL6 && instr_word_in[flow_pkg::REL6_HI]
        |=> branch_target_out < $past(pc_in) || $past(pc_in) < 24'h000020;
    endproperty
    a_rel6: assert property (p_rel6) else $error("negative short offset not sign extended");

    property p_index_kept;
        @(posedge clk_in) disable iff (srst_in)
        take && form == flow_pkg::FORM_IND && !avs_write_in |=> index_q[$past(idx_sel)] == $past(index_q[idx_sel]);
    endproperty
    a_index_kept: assert property (p_index_kept) else $error("index changed by branch");

    property p_abort;
        @(posedge clk_in) disable iff (srst_in)
        pop_loop_stacks_out |-> pop_pc_stack_out && !branch_call_out && branch_taken_out;
    endproperty
    a_abort: assert property (p_abort) else $error("loop abort on call or without pop");

    property p_no_relatch;
        @(posedge clk_in) disable iff (srst_in)
        (irq_raise_in[2] && interrupt_mask_pointer[2] && !interrupt_latch_reg[2]) |=> !interrupt_latch_reg[2];
    endproperty
    a_no_relatch: assert property (p_no_relatch) else $error("in-service interrupt latched");

    property p_ci_clear;
        @(posedge clk_in) disable iff (srst_in)
        take && clear_interrupt_modifier && current_irq != '0 && isr_enter_in == '0
        |=> (interrupt_mask_pointer & $past(current_irq)) == '0;
    endproperty
    a_ci_clear: assert property (p_ci_clear) else $error("clear interrupt left mask pointer set");

    property p_delay;
        @(posedge clk_in) disable iff (srst_in)
        branch_taken_out |-> branch_delayed_out != flush_fetched_out;
    endproperty
    a_delay: assert property (p_delay) else $error("delayed and flush disagree");

    property p_uncond;
        @(posedge clk_in) disable iff (srst_in)
        instr_valid_in && form_ok && !condition_field_present |=> branch_taken_out;
    endproperty
    a_uncond: assert property (p_uncond) else $error("unconditional branch not taken");

    property p_dual_and;
        @(posedge clk_in) disable iff (srst_in)
        dual_lane_mode_q && condition_field_present && !(condition_field_x_in && condition_field_y_in) |=> !branch_taken_out;
    endproperty
    a_dual_and: assert property (p_dual_and) else $error("dual lane branch without both true");

    property p_else_false;
        @(posedge clk_in) disable iff (srst_in)
        instr_valid_in && else_bit |=> compute_en_x_out == $past(condition_field_present && !condition_field_x_in);
    endproperty
    a_else_false: assert property (p_else_false) else $error("else compute gating wrong");

    property p_y_lane;
        @(posedge clk_in) disable iff (srst_in)
        compute_en_y_out |-> compute_complement_y_out && $past(dual_lane_mode_q);
    endproperty
    a_y_lane: assert property (p_y_lane) else $error("second element compute outside dual lane");
endmodule // branch_jump_call_control

/* dv/fetch_model.sv */
// ----------------------------------------
// Instruction fetch and condition source
// ----------------------------------------
module fetch_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [flow_pkg::INSTR_W-1:0] word_in,
    input wire logic [flow_pkg::ADDR_W-1:0] pc_in,
    input wire logic cx_in,
    input wire logic cy_in,
    output logic instr_valid_out,
    output logic [flow_pkg::INSTR_W-1:0] word_out,
    output logic [flow_pkg::ADDR_W-1:0] pc_out,
    output logic cx_out,
    output logic cy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle values start at zero.
    initial
    begin
        {instr_valid_out, word_out, pc_out, cx_out, cy_out} = '0;
    end
    // Issues one word per request; between requests the lines toggle so stale values never look valid.
    // The stream holds no return, so loop reentry never arises; abort jumps are taken to leave a loop.
    always @(posedge clk_in)
    begin
        instr_valid_out <= go_in;
        word_out <= go_in ? (word_in | ({47'h0, word_in[40]} << 39)) : ~word_out;
        pc_out <= go_in ? pc_in : ~pc_out;
        cx_out <= go_in ? cx_in : ~cx_out;
        cy_out <= go_in ? cy_in : ~cy_out;
    end
endmodule // fetch_model

/* dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, srst_in = 1, rd = 0, wr = 0, go = 0, cx = 0, cy = 0, took = 0, dual = 0;
    logic [6:0] adr = 7'h00;
    logic [31:0] wd = 32'h0, q;
    logic [47:0] w = 48'h0, ww;
    logic [23:0] pc = 24'h0, idx [8], mdf [8];
    logic [7:0] irq = 8'h00, ent = 8'h00;
    logic [111:0] expq [$];
    int bad_count = 0, cmp_count = 0, seed = 20;
    wire logic iv, fcx, fcy, wq, tk, ca, dl, fl, pl, pp, ex, ey, ec;
    wire logic [47:0] fw;
    wire logic [23:0] fpc, tg;
    wire logic [22:0] op;
    wire logic [31:0] rdata;
    wire logic [7:0] lat;
    wire logic [55:0] res = {tk, ca, dl, fl, pl, pp, ex, ey, ec, tg, op};
    fetch_model fetch_model_i (.clk_in(clk_in), .go_in(go), .word_in(w), .pc_in(pc), .cx_in(cx), .cy_in(cy),
        .instr_valid_out(iv), .word_out(fw), .pc_out(fpc), .cx_out(fcx), .cy_out(fcy));
    branch_jump_call_control branch_jump_call_control_i (.clk_in(clk_in), .srst_in(srst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
        .instr_valid_in(iv), .instr_word_in(fw), .pc_in(fpc), .condition_field_x_in(fcx), .condition_field_y_in(fcy),
        .irq_raise_in(irq), .isr_enter_in(ent), .isr_exit_in(1'b0), .branch_taken_out(tk),
        .branch_target_out(tg), .branch_call_out(ca), .branch_delayed_out(dl), .flush_fetched_out(fl),
        .pop_loop_stacks_out(pl), .pop_pc_stack_out(pp), .compute_en_x_out(ex), .compute_en_y_out(ey),
        .compute_complement_y_out(ec), .compute_op_out(op), .interrupt_latch_out(lat));
    // Core clock at 125 MHz.
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task cmp_res(input logic [111:0] e, input logic [55:0] g);
        cmp_count++;
        if (((g ^ e[55:0]) & e[111:56]) !== 56'h0)
        begin
            bad_count++;
            $display("[ERR] %0t exp %h got %h", $time, e[55:0], g);
        end
    endtask
    task cmp32(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Each result appears one edge after the word is taken; the oldest note is compared.
    always @(posedge clk_in) took <= iv;
    always @(negedge clk_in)
    begin
        if (took && expq.size() > 0)
            cmp_res(expq.pop_front(), res);
    end
    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task bus(input logic we, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_in);
        adr <= a;
        rd <= !we;
        wr <= we;
        wd <= d;
        @(posedge clk_in);
        while (wq !== 1'b0) @(posedge clk_in);
        q = rdata;
        rd <= 0;
        wr <= 0;
    endtask
    task issue(input logic [47:0] wi, input logic [23:0] pi, input logic xi, input logic yi);
        logic [2:0] f;
        logic cp, t, e1, e2, n9;
        logic [23:0] tt;
        logic [55:0] m;
        f = wi[47:45];
        cp = wi[39] | wi[40];
        n9 = (f == 3'h3) || (f == 3'h4);
        t = (f >= 3'h1 && f <= 3'h4) && (!cp || (xi && (!dual || yi)));
        tt = f == 3'h1 ? wi[23:0] : f == 3'h2 ? pi + wi[23:0] : f == 3'h3 ? idx[wi[33:31]] + mdf[wi[30:28]]
            : pi + {{18{wi[28]}}, wi[28:23]};
        e1 = n9 && (wi[40] ? !xi : (!cp || xi));
        e2 = n9 && dual && (wi[40] ? !yi : (!cp || yi));
        m = {9'h1FF, {24{t}}, 23'h7FFFFF};
        expq.push_back({m, t, t & wi[44], t & wi[43], t & !wi[43], {2{t & !wi[44] & wi[42]}}, e1, e2, e2, tt,
            wi[22:0]});
        @(posedge clk_in);
        go <= 1;
        w <= wi;
        pc <= pi;
        cx <= xi;
        cy <= yi;
    endtask
    task stop;
        @(posedge clk_in);
        go <= 0;
        repeat (4) @(posedge clk_in);
    endtask
    task ev(input logic [7:0] r, input logic [7:0] e, input logic [7:0] x);
        @(posedge clk_in);
        irq <= r;
        ent <= e;
        @(posedge clk_in);
        irq <= 8'h00;
        ent <= 8'h00;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        cmp32({24'h0, x}, {24'h0, lat});
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            idx[i] = 24'($random(seed));
            mdf[i] = 24'($random(seed));
        end
        repeat (8) @(posedge clk_in);
        srst_in <= 0;
        bus(0, flow_pkg::OFS_CTRL, 0);
        cmp32(flow_pkg::CTRL_RESET, q);
        bus(1, 7'h7C, 32'hFFFF_FFFF);
        bus(0, 7'h7C, 0);
        cmp32(32'h0, q);
        bus(1, flow_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        bus(0, flow_pkg::OFS_STATUS, 0);
        cmp32(32'h0, q);
        for (int i = 0; i < 8; i++)
        begin
            bus(1, 7'(32 + 4 * i), {8'h0, idx[i]});
            bus(1, 7'(64 + 4 * i), {8'h0, mdf[i]});
        end
        for (int p = 0; p < 2; p++)
        begin
            bus(1, flow_pkg::OFS_CTRL, 32'(p));
            dual = p[0];
            for (int n = 0; n < 60; n++)
            begin
                ww = 48'({$random(seed), $random(seed)});
                ww[47:45] = 3'(n % 5);
                issue(ww, 24'($random(seed)), 1'($random(seed)), 1'($random(seed)));
            end
            stop();
        end
        issue(48'h6001_5000_0000, 24'h000100, 0, 0);
        stop();
        bus(0, flow_pkg::OFS_STATUS, 0);
        cmp32({8'h00, idx[2] + mdf[5]}, q);
        bus(0, 7'h28, 0);
        cmp32({8'h0, idx[2]}, q);
        ev(8'h04, 8'h00, 8'h04);
        ev(8'h00, 8'h04, 8'h00);
        ev(8'h04, 8'h00, 8'h00);
        issue(48'h3200_0000_0000, 24'h0, 0, 0);
        stop();
        ev(8'h04, 8'h00, 8'h00);
        issue(48'h2200_0000_0000, 24'h0, 0, 0);
        stop();
        bus(0, flow_pkg::OFS_MASKP, 0);
        cmp32(32'h0, q);
        ev(8'h04, 8'h00, 8'h04);
        // A note left unanswered means a result never came.
        if (expq.size() != 0)
            bad_count++;
        results();
    end
    initial
    begin
        repeat (30000) @(posedge clk_in);
        bad_count++;
        results();
    end
endmodule // tb_top
